// file: logic/dlm_pkg.sv
`default_nettype none
package dlm_pkg;

    localparam int unsigned NUM_REF        = 4;

    // System clock and the monitor timing unit
    localparam int unsigned CLK_HZ         = 40_000_000;
    localparam int unsigned CLK_NS         = 25;
    localparam int unsigned MON_HZ         = 100_000_000;
    localparam int unsigned MON_UNIT_NS    = 1_000_000_000 / MON_HZ;

    // Lock detector step
    localparam int unsigned LOCK_STEP_MS   = 4;
    localparam int unsigned LOCK_STEP_CYC  = LOCK_STEP_MS * (CLK_HZ / 1000);

    // Slew limiter budget window: ppm equals ns per ms
    localparam int unsigned SLEW_WIN_MS    = 1;
    localparam int unsigned SLEW_WIN_CYC   = SLEW_WIN_MS * (CLK_HZ / 1000);
    localparam logic [7:0]  SLEW_RST_PPM   = 8'h38;
    localparam logic [7:0]  SLEW_MAX_PPM   = 8'hBA;

    // Multi-period time base
    localparam int unsigned TIMEBASE_S     = 10;
    localparam int unsigned TB_TICKS       = TIMEBASE_S * CLK_HZ;

    // Hysteresis limits in thousandths of a ppm
    localparam int unsigned NEAR_DEF_MPPM  = 64_713;
    localparam int unsigned FAR_DEF_MPPM   = 82_487;
    localparam int unsigned NEAR_RLX_MPPM  = 240_000;
    localparam int unsigned FAR_RLX_MPPM   = 250_000;
    localparam int unsigned MPPM_PER_UNIT  = 1_000_000_000;

    // Control register fields
    localparam int unsigned RCC_REALIGN_BIT = 7;
    localparam int unsigned RCC_MODE_LSB    = 0;
    localparam int unsigned RCC_REF_LSB     = 3;
    localparam int unsigned PLC_LIMSEL_BIT  = 2;
    localparam int unsigned MASK_MP_LSB     = 4;

    localparam logic [2:0]  MODE_AUTO_RR    = 3'h0;
    localparam logic [2:0]  MODE_AUTO_PREF  = 3'h1;
    localparam logic [2:0]  MODE_MANUAL     = 3'h2;

    typedef struct packed {
        logic       lock;
        logic       holdover;
        logic [1:0] sel;
    } dlm_rcs_t;

    typedef struct packed {
        logic valid;
        logic mp_fail;
        logic sp_fail;
    } dlm_ref_stat_t;

    typedef struct packed {
        logic [15:0] upper;
        logic [15:0] lower;
    } dlm_sp_lim_t;

    typedef enum logic [1:0] {
        SEL_TRACK = 2'b01,
        SEL_HOLD  = 2'b10
    } dlm_sel_state_t;

endpackage
`default_nettype wire

// file: logic/dlm_lock_refmon.sv
`timescale 1ns/1ps
`default_nettype none

module dlm_ref_mon #(
    parameter int unsigned TB_TICKS = dlm_pkg::TB_TICKS
) (
    // Clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  nrst_i,
    // Reference and settings
    input  wire logic                  ref_i,
    input  wire logic [31:0]           tb_cycles_i,
    input  wire dlm_pkg::dlm_sp_lim_t  lim_i,
    input  wire logic                  limit_set_select_i,
    input  wire logic                  mask_sp_i,
    input  wire logic                  mask_mp_i,
    // Result
    output dlm_pkg::dlm_ref_stat_t     stat_o
);
    import dlm_pkg::*;

    localparam logic [63:0] NEAR_DEF = 64'(TB_TICKS) * 64'(NEAR_DEF_MPPM) / 64'(MPPM_PER_UNIT);
    localparam logic [63:0] FAR_DEF  = 64'(TB_TICKS) * 64'(FAR_DEF_MPPM) / 64'(MPPM_PER_UNIT);
    localparam logic [63:0] NEAR_RLX = 64'(TB_TICKS) * 64'(NEAR_RLX_MPPM) / 64'(MPPM_PER_UNIT);
    localparam logic [63:0] FAR_RLX  = 64'(TB_TICKS) * 64'(FAR_RLX_MPPM) / 64'(MPPM_PER_UNIT);
    localparam logic [31:0] TB_MAX   = 32'(64'(TB_TICKS) + FAR_RLX + 64'd1);

    logic        ref_prev_q;
    logic        edge_w;
    logic [19:0] per_cnt_q;
    logic        seen_q;
    logic [23:0] per10_w;
    logic        sp_fail_q;
    logic        tb_run_q;
    logic [31:0] tb_ref_q;
    logic [31:0] tb_tick_q;
    logic        done_w;
    logic [31:0] dev_w;
    logic [31:0] near_w;
    logic [31:0] far_w;
    logic        want_w;
    logic        pend_q;
    logic        mp_fail_q;

    assign edge_w  = ref_i & ~ref_prev_q;
    // Elapsed time converted to 10 ns units of the monitor clock
    // Product taken at 32 bits: a saturated count times the tick length overflows 24 bits
    assign per10_w = 24'((32'(per_cnt_q) * 32'(CLK_NS)) / 32'(MON_UNIT_NS));

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            ref_prev_q <= 1'b0;
            per_cnt_q  <= 20'h00001;
            seen_q     <= 1'b0;
        end else begin
            ref_prev_q <= ref_i;
            if (edge_w) begin
                per_cnt_q <= 20'h00001;
                seen_q    <= 1'b1;
            end else if (per_cnt_q != 20'hFFFFF) begin
                per_cnt_q <= per_cnt_q + 20'h00001;
            end
        end
    end

    // Single-period check; a missing edge fails as soon as the upper limit passes
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            sp_fail_q <= 1'b0;
        end else if (seen_q && edge_w) begin
            sp_fail_q <= (per10_w > 24'(lim_i.upper)) || (per10_w < 24'(lim_i.lower));
        end else if (seen_q && per10_w > 24'(lim_i.upper)) begin
            sp_fail_q <= 1'b1;
        end
    end

    // Time base counted in reference cycles, measured in system ticks
    assign done_w = tb_run_q && ((edge_w && (tb_ref_q + 32'h1 >= tb_cycles_i)) || tb_tick_q > TB_MAX);
    assign dev_w  = (tb_tick_q >= 32'(TB_TICKS)) ? tb_tick_q - 32'(TB_TICKS) : 32'(TB_TICKS) - tb_tick_q;
    assign near_w = limit_set_select_i ? 32'(NEAR_RLX) : 32'(NEAR_DEF);
    assign far_w  = limit_set_select_i ? 32'(FAR_RLX) : 32'(FAR_DEF);
    // Fail only beyond far, recover only inside near: the grey zone holds
    assign want_w = mp_fail_q ? (dev_w <= near_w) : (dev_w > far_w);

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            tb_run_q  <= 1'b0;
            tb_ref_q  <= 32'h0;
            tb_tick_q <= 32'h0;
        end else if (done_w) begin
            tb_run_q  <= 1'b0;
        end else if (!tb_run_q) begin
            // Starts at one so the closing edge sees the full span of ticks
            tb_run_q  <= edge_w;
            tb_ref_q  <= 32'h0;
            tb_tick_q <= 32'h1;
        end else begin
            tb_tick_q <= tb_tick_q + 32'h1;
            if (edge_w) begin
                tb_ref_q <= tb_ref_q + 32'h1;
            end
        end
    end

    // Reset to failed so a reference must earn validity by two measurements
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            pend_q    <= 1'b0;
            mp_fail_q <= 1'b1;
        end else if (done_w) begin
            if (want_w && pend_q) begin
                mp_fail_q <= ~mp_fail_q;
                pend_q    <= 1'b0;
            end else begin
                pend_q    <= want_w;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            stat_o <= '{valid: 1'b0, mp_fail: 1'b1, sp_fail: 1'b0};
        end else begin
            stat_o.sp_fail <= sp_fail_q;
            stat_o.mp_fail <= mp_fail_q;
            stat_o.valid   <= !(sp_fail_q && !mask_sp_i) && !(mp_fail_q && !mask_mp_i);
        end
    end

endmodule // dlm_ref_mon

module dlm_lock_refmon #(
    parameter int unsigned LOCK_STEP_CYC = dlm_pkg::LOCK_STEP_CYC,
    parameter int unsigned SLEW_WIN_CYC  = dlm_pkg::SLEW_WIN_CYC,
    parameter int unsigned TB_TICKS      = dlm_pkg::TB_TICKS
) (
    // Clock and reset
    input  wire logic                                        ref_clk_i,
    input  wire logic                                        nrst_i,
    // References and monitor settings
    input  wire logic [dlm_pkg::NUM_REF-1:0]                 ref_in_i,
    input  wire logic [dlm_pkg::NUM_REF-1:0][31:0]           ref_tb_cycles_i,
    input  wire dlm_pkg::dlm_sp_lim_t [dlm_pkg::NUM_REF-1:0] sp_limits_i,
    // Phase detector
    input  wire logic signed [15:0]                          phase_val_i,
    input  wire logic                                        mode_change_i,
    // Control registers
    input  wire logic [15:0]                                 lock_threshold_reg_i,
    input  wire logic [7:0]                                  lock_interval_reg_i,
    input  wire logic [7:0]                                  reference_change_control_reg_i,
    input  wire logic [7:0]                                  pll_control_reg_i,
    input  wire logic [7:0]                                  reference_mask_reg_i,
    input  wire logic                                        slew_limit_wr_i,
    input  wire logic [7:0]                                  slew_limit_wdata_i,
    // Status
    output dlm_pkg::dlm_rcs_t                                reference_change_status_reg_o,
    output dlm_pkg::dlm_ref_stat_t [dlm_pkg::NUM_REF-1:0]    reference_status_reg_o,
    output logic [7:0]                                       slew_limit_reg_o,
    // Loop steering
    output logic signed [15:0]                               phase_corr_o,
    output logic signed [15:0]                               phase_adj_o,
    output logic                                             phase_adj_vld_o
);
    import dlm_pkg::*;

    logic [NUM_REF-1:0] valid_w;
    logic [2:0]         mode_w;
    logic [1:0]         ref_field_w;

    assign mode_w      = reference_change_control_reg_i[RCC_MODE_LSB +: 3];
    assign ref_field_w = reference_change_control_reg_i[RCC_REF_LSB +: 2];

    for (genvar g = 0; g < NUM_REF; g++) begin : g_mon
        dlm_ref_mon #(
            .TB_TICKS (TB_TICKS)
        ) u_mon (
            .ref_clk_i          (ref_clk_i),
            .nrst_i             (nrst_i),
            .ref_i              (ref_in_i[g]),
            .tb_cycles_i        (ref_tb_cycles_i[g]),
            .lim_i              (sp_limits_i[g]),
            .limit_set_select_i (pll_control_reg_i[PLC_LIMSEL_BIT]),
            .mask_sp_i          (reference_mask_reg_i[g]),
            .mask_mp_i          (reference_mask_reg_i[MASK_MP_LSB + g]),
            .stat_o             (reference_status_reg_o[g])
        );
        assign valid_w[g] = reference_status_reg_o[g].valid;
    end

    // Lock detector
    logic [31:0] step_cnt_q;
    logic        step_w;
    logic [7:0]  int_cnt_q;
    logic [7:0]  int_len_w;
    logic [16:0] mag_w;
    logic        over_w;
    logic        exceed_q;
    logic        lock_q;

    assign step_w    = (step_cnt_q == 32'(LOCK_STEP_CYC - 1));
    assign int_len_w = (lock_interval_reg_i == 8'h00) ? 8'h01 : lock_interval_reg_i;
    assign mag_w     = phase_val_i[15] ? 17'(-$signed({phase_val_i[15], phase_val_i})) : {1'b0, phase_val_i};
    assign over_w    = (mag_w >= {1'b0, lock_threshold_reg_i});

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            step_cnt_q <= 32'h0;
        end else begin
            step_cnt_q <= step_w ? 32'h0 : step_cnt_q + 32'h1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            int_cnt_q <= 8'h00;
            exceed_q  <= 1'b0;
            lock_q    <= 1'b0;
        end else if (step_w && (int_cnt_q + 8'h01 >= int_len_w)) begin
            lock_q    <= !(exceed_q || over_w);
            exceed_q  <= 1'b0;
            int_cnt_q <= 8'h00;
        end else begin
            exceed_q  <= exceed_q || over_w;
            if (step_w) begin
                int_cnt_q <= int_cnt_q + 8'h01;
            end
        end
    end

    // Reference selection
    dlm_sel_state_t state_q;
    dlm_sel_state_t state_d;
    logic [1:0]     sel_q;
    logic [1:0]     sel_d;
    logic [1:0]     cand;
    logic           rearr_w;

    always_comb begin
        state_d = SEL_TRACK;
        sel_d   = sel_q;
        cand    = sel_q;
        case (mode_w)
            MODE_AUTO_RR: begin
                if (!valid_w[sel_q]) begin
                    state_d = SEL_HOLD;
                    for (int i = NUM_REF - 1; i >= 1; i--) begin
                        cand = sel_q + 2'(i);
                        if (valid_w[cand]) begin
                            sel_d   = cand;
                            state_d = SEL_TRACK;
                        end
                    end
                end
            end
            MODE_AUTO_PREF: begin
                cand = ref_field_w + 2'h1;
                if (valid_w[ref_field_w]) begin
                    sel_d = ref_field_w;
                end else if (valid_w[cand]) begin
                    sel_d = cand;
                end else begin
                    state_d = SEL_HOLD;
                end
            end
            default: begin
                sel_d = ref_field_w;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_q <= SEL_HOLD;
            sel_q   <= 2'h0;
        end else begin
            state_q <= state_d;
            sel_q   <= sel_d;
        end
    end

    assign rearr_w = (sel_d != sel_q) || (state_d != state_q) || mode_change_i;

    // Phase preservation: a new baseline hides the step that a rearrangement makes
    logic               realign_prev_q;
    logic signed [15:0] offset_q;
    logic signed [15:0] corr_w;

    assign corr_w = 16'(phase_val_i - offset_q);

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            realign_prev_q <= 1'b0;
            offset_q       <= 16'sh0000;
        end else begin
            realign_prev_q <= reference_change_control_reg_i[RCC_REALIGN_BIT];
            if (reference_change_control_reg_i[RCC_REALIGN_BIT] && !realign_prev_q) begin
                offset_q <= 16'sh0000;
            end else if (rearr_w) begin
                offset_q <= phase_val_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            phase_corr_o <= 16'sh0000;
        end else begin
            phase_corr_o <= corr_w;
        end
    end

    // Slew limiter; the clamp at write keeps any value within the limiter reach
    logic [31:0]        win_cnt_q;
    logic signed [15:0] slew_s_w;

    assign slew_s_w = $signed({8'h00, slew_limit_reg_o});

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            slew_limit_reg_o <= SLEW_RST_PPM;
        end else if (slew_limit_wr_i) begin
            slew_limit_reg_o <= (slew_limit_wdata_i > SLEW_MAX_PPM) ? SLEW_MAX_PPM : slew_limit_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            win_cnt_q       <= 32'h0;
            phase_adj_o     <= 16'sh0000;
            phase_adj_vld_o <= 1'b0;
        end else begin
            phase_adj_vld_o <= 1'b0;
            win_cnt_q       <= win_cnt_q + 32'h1;
            if (win_cnt_q == 32'(SLEW_WIN_CYC - 1)) begin
                win_cnt_q       <= 32'h0;
                phase_adj_vld_o <= 1'b1;
                if (state_q == SEL_HOLD) begin
                    phase_adj_o <= 16'sh0000;
                end else if (phase_corr_o > slew_s_w) begin
                    phase_adj_o <= slew_s_w;
                end else if (phase_corr_o < -slew_s_w) begin
                    phase_adj_o <= -slew_s_w;
                end else begin
                    phase_adj_o <= phase_corr_o;
                end
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            reference_change_status_reg_o <= '{lock: 1'b0, holdover: 1'b1, sel: 2'h0};
        end else begin
            reference_change_status_reg_o.lock     <= lock_q;
            reference_change_status_reg_o.holdover <= (state_q == SEL_HOLD);
            reference_change_status_reg_o.sel      <= sel_q;
        end
    end

endmodule // dlm_lock_refmon
`default_nettype wire

// file: dv/dlm_lock_refmon_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dlm_lock_refmon_checker
    import dlm_pkg::*;
#(
    parameter int LOCK_STEP_CYC = 20,
    parameter int SLEW_WIN_CYC  = 10
) (
    // Clock and reset
    input wire logic                                  ref_clk_i,
    input wire logic                                  nrst_i,
    // Watched inputs
    input wire logic signed [15:0]                    phase_val_i,
    input wire logic                                  mode_change_i,
    input wire logic [15:0]                           lock_threshold_reg_i,
    input wire logic [7:0]                            lock_interval_reg_i,
    input wire logic [7:0]                            reference_change_control_reg_i,
    input wire logic [7:0]                            reference_mask_reg_i,
    input wire logic                                  slew_limit_wr_i,
    input wire logic [7:0]                            slew_limit_wdata_i,
    // Watched outputs
    input wire dlm_pkg::dlm_rcs_t                     reference_change_status_reg_o,
    input wire dlm_pkg::dlm_ref_stat_t [NUM_REF-1:0]  reference_status_reg_o,
    input wire logic [7:0]                            slew_limit_reg_o,
    input wire logic signed [15:0]                    phase_corr_o,
    input wire logic signed [15:0]                    phase_adj_o,
    input wire logic                                  phase_adj_vld_o
);
    // Two steps of interval plus the status register lag
    localparam int LOCK_WIN = 2 * LOCK_STEP_CYC + 3;

    function automatic logic [16:0] mag(input logic signed [15:0] v);
        logic signed [16:0] w;
        w = v;
        return (w < 0) ? 17'(-w) : 17'(w);
    endfunction

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    sequence s_rearrange;
        mode_change_i && !reference_change_control_reg_i[7];
    endsequence
    sequence s_quiet;
        $stable(phase_val_i) && !mode_change_i && $stable(reference_change_control_reg_i);
    endsequence
    sequence s_realign;
        $rose(reference_change_control_reg_i[7]) ##1 !mode_change_i;
    endsequence

    a_reset_vals: assert property (disable iff (1'b0) !nrst_i |=> slew_limit_reg_o == 8'h38 &&
        reference_change_status_reg_o.holdover && !reference_change_status_reg_o.lock && !phase_adj_vld_o)
        else $error("reset values wrong");
    a_slew_write: assert property (slew_limit_wr_i |=> slew_limit_reg_o ==
        (($past(slew_limit_wdata_i) > 8'hBA) ? 8'hBA : $past(slew_limit_wdata_i))) else $error("slew write wrong");
    a_slew_hold: assert property (!slew_limit_wr_i |=> $stable(slew_limit_reg_o))
        else $error("slew changed without write");
    a_adj_bound: assert property (phase_adj_vld_o && $stable(slew_limit_reg_o) |->
        phase_adj_o <= $signed({8'h00, slew_limit_reg_o}) && phase_adj_o >= -$signed({8'h00, slew_limit_reg_o}))
        else $error("phase step above slew limit");
    a_window_gap: assert property (phase_adj_vld_o |=> !phase_adj_vld_o [*8])
        else $error("adjust pulses too close");
    a_window_due: assert property (phase_adj_vld_o |-> ##SLEW_WIN_CYC phase_adj_vld_o)
        else $error("adjust pulse missing");
    a_corr_rebase: assert property (s_rearrange ##1 s_quiet |=> phase_corr_o == 16'sh0000)
        else $error("phase not kept over rearrangement");
    a_realign_zero: assert property (s_realign |=> phase_corr_o == $past(phase_val_i))
        else $error("realign did not clear offset");
    a_lock_rise: assert property ($rose(reference_change_status_reg_o.lock) |->
        mag($past(phase_val_i, 3)) < {1'b0, $past(lock_threshold_reg_i, 3)}) else $error("lock with phase over");
    a_lock_drop: assert property (reference_change_status_reg_o.lock && lock_interval_reg_i == 8'h02 &&
        mag(phase_val_i) >= {1'b0, lock_threshold_reg_i} |-> ##[1:LOCK_WIN] !reference_change_status_reg_o.lock)
        else $error("lock not withdrawn");
    for (genvar k = 0; k < NUM_REF; k++) begin : g_ref
        a_valid_mask: assert property ($stable(reference_mask_reg_i) |-> reference_status_reg_o[k].valid ==
            (!(reference_status_reg_o[k].sp_fail && !reference_mask_reg_i[k]) &&
             !(reference_status_reg_o[k].mp_fail && !reference_mask_reg_i[MASK_MP_LSB+k])))
            else $error("valid flag inconsistent");
    end
endmodule // dlm_lock_refmon_checker

bind dlm_lock_refmon dlm_lock_refmon_checker #(.LOCK_STEP_CYC(LOCK_STEP_CYC), .SLEW_WIN_CYC(SLEW_WIN_CYC)) u_chk (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .phase_val_i(phase_val_i), .mode_change_i(mode_change_i),
    .lock_threshold_reg_i(lock_threshold_reg_i), .lock_interval_reg_i(lock_interval_reg_i),
    .reference_change_control_reg_i(reference_change_control_reg_i), .reference_mask_reg_i(reference_mask_reg_i),
    .slew_limit_wr_i(slew_limit_wr_i), .slew_limit_wdata_i(slew_limit_wdata_i),
    .reference_change_status_reg_o(reference_change_status_reg_o), .reference_status_reg_o(reference_status_reg_o),
    .slew_limit_reg_o(slew_limit_reg_o), .phase_corr_o(phase_corr_o), .phase_adj_o(phase_adj_o),
    .phase_adj_vld_o(phase_adj_vld_o));
`default_nettype wire

// file: dv/dlm_ref_src.sv
`timescale 1ns/1ps
`default_nettype none
module dlm_ref_src #(
    parameter int unsigned HALF = 20
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    // Per source run control
    input  wire logic [3:0]  run_i,
    // Reference clocks
    output logic [3:0]       ref_o
);
    logic [15:0] cnt_q;

    // Shared divider; a stopped source freezes like a lost clock
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            cnt_q <= 16'h0000;
            ref_o <= 4'h0;
        end else begin
            cnt_q <= (cnt_q == 16'(HALF - 1)) ? 16'h0000 : cnt_q + 16'h0001;
            if (cnt_q == 16'(HALF - 1)) begin
                ref_o <= ref_o ^ run_i;
            end
        end
    end
endmodule // dlm_ref_src
`default_nettype wire

// file: dv/dlm_lock_refmon_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dlm_lock_refmon_tb_top;
    import dlm_pkg::*;
    logic                          ref_clk_i = 1'b0;
    logic                          nrst_i = 1'b0;
    logic [NUM_REF-1:0]            ref_in;
    logic [NUM_REF-1:0]            run;
    logic [NUM_REF-1:0][31:0]      tbc;
    dlm_sp_lim_t [NUM_REF-1:0]     lims;
    logic signed [15:0]            phase;
    logic                          mode_chg;
    logic [15:0]                   thr;
    logic [7:0]                    intv, rcc, plc, mask, swd, slew;
    logic                          swr, vld;
    dlm_rcs_t                      rcs;
    dlm_ref_stat_t [NUM_REF-1:0]   stat;
    logic signed [15:0]            corr, adj;
    int                            num_errors = 0;
    int                            total_checks = 0;
    int                            cycles = 0;

    always #12.5 ref_clk_i = ~ref_clk_i;

    dlm_ref_src #(.HALF(20)) u_src (.clk_i(ref_clk_i), .nrst_i(nrst_i), .run_i(run), .ref_o(ref_in));

    dlm_lock_refmon #(.LOCK_STEP_CYC(20), .SLEW_WIN_CYC(10), .TB_TICKS(4000)) dut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .ref_in_i(ref_in), .ref_tb_cycles_i(tbc), .sp_limits_i(lims),
        .phase_val_i(phase), .mode_change_i(mode_chg), .lock_threshold_reg_i(thr), .lock_interval_reg_i(intv),
        .reference_change_control_reg_i(rcc), .pll_control_reg_i(plc), .reference_mask_reg_i(mask),
        .slew_limit_wr_i(swr), .slew_limit_wdata_i(swd), .reference_change_status_reg_o(rcs),
        .reference_status_reg_o(stat), .slew_limit_reg_o(slew), .phase_corr_o(corr), .phase_adj_o(adj),
        .phase_adj_vld_o(vld));

    task automatic end_sim();
        if (num_errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask

    task automatic wr_slew(input logic [7:0] v);
        @(posedge ref_clk_i);
        swr <= 1'b1;
        swd <= v;
        @(posedge ref_clk_i);
        swr <= 1'b0;
        @(negedge ref_clk_i);
    endtask

    always @(posedge ref_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            num_errors++;
            end_sim();
        end
    end

    initial begin
        run = 4'hF;
        phase = 16'sh0005;
        mode_chg = 1'b0;
        thr = 16'h0064;
        intv = 8'h02;
        rcc = 8'h00;
        plc = 8'h00;
        mask = 8'h00;
        swr = 1'b0;
        swd = 8'h00;
        // Reference period is 1000 ns, so limits of 110 and 90 units bracket it
        for (int k = 0; k < NUM_REF; k++) begin
            tbc[k] = 32'h0000_0064;
            lims[k] = '{upper: 16'h006E, lower: 16'h005A};
        end
        settle(19);
        check(rcs, 4'h4);
        check(slew, 8'h38);
        check(stat[1], 3'h2);
        @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        wr_slew(8'hFF);
        check(slew, 8'hBA);
        wr_slew(8'h20);
        check(slew, 8'h20);
        settle(4300);
        check(stat[0], 3'h2);
        settle(4000);
        for (int k = 0; k < NUM_REF; k++) begin
            check(stat[k], 3'h4);
        end
        check(rcs, 4'h8);
        @(posedge ref_clk_i);
        phase <= -16'sd100;
        @(posedge ref_clk_i);
        phase <= 16'sh0005;
        settle(45);
        check(rcs.lock, 1'b0);
        settle(90);
        check(rcs.lock, 1'b1);
        @(posedge ref_clk_i);
        phase <= 16'sh001E;
        mode_chg <= 1'b1;
        @(posedge ref_clk_i);
        mode_chg <= 1'b0;
        settle(3);
        check(corr, 32'h0);
        @(posedge ref_clk_i);
        rcc <= 8'h80;
        settle(3);
        check(corr, 32'h1E);
        settle(10);
        check(adj, 32'h1E);
        @(posedge ref_clk_i);
        rcc <= 8'h00;
        run <= 4'hE;
        settle(80);
        check(stat[0], 3'h1);
        check(rcs.sel, 2'h1);
        @(posedge ref_clk_i);
        mask <= 8'h11;
        settle(3);
        check(stat[0].valid, 1'b1);
        @(posedge ref_clk_i);
        rcc <= 8'h12;
        settle(4);
        check(rcs.sel, 2'h2);
        @(posedge ref_clk_i);
        rcc <= 8'h19;
        settle(4);
        check(rcs.sel, 2'h3);
        // Ref 3 now runs 1% fast against its nominal count
        @(posedge ref_clk_i);
        tbc[3] <= 32'h0000_0063;
        plc <= 8'h04;
        settle(12500);
        check(stat[3], 3'h2);
        check(rcs, 4'h8);
        end_sim();
    end
endmodule // dlm_lock_refmon_tb_top
`default_nettype wire
